// ### design/sarct_consts.vh
// Register addresses, field positions, reset values and clock divisors of the split timer.
`ifndef SARCT_CONSTS_VH
`define SARCT_CONSTS_VH
// Second timer instance (capture on the slow oscillator).
`define SARCT_B_CTRL_ADDR 8'h91
`define SARCT_B_RLL_ADDR 8'h92
`define SARCT_B_RLH_ADDR 8'h93
`define SARCT_B_CNTL_ADDR 8'h94
`define SARCT_B_CNTH_ADDR 8'h95
// First timer instance (capture on the input pin).
`define SARCT_A_CTRL_ADDR 8'hc8
`define SARCT_A_RLL_ADDR 8'hca
`define SARCT_A_RLH_ADDR 8'hcb
`define SARCT_A_CNTL_ADDR 8'hcc
`define SARCT_A_CNTH_ADDR 8'hcd
// Control register fields.
`define SARCT_HFLAG_BIT 7
`define SARCT_LFLAG_BIT 6
`define SARCT_LIEN_BIT 5
`define SARCT_CAPEN_BIT 4
`define SARCT_SPLIT_BIT 3
`define SARCT_RUN_BIT 2
`define SARCT_RSVD_BIT 1
`define SARCT_XCLK_BIT 0
`define SARCT_REG_RESET 8'h00
// Clock divisors.
`define SARCT_SYS_DIV 12
`define SARCT_EXT_DIV 8
`define SARCT_DIV_W 4
`endif

// ### design/sarct_timer.v
// Split 16-bit or dual 8-bit auto-reload timer with capture, reached through special-function registers.
//
// Overview of operation
// - Reload-high byte feeds the high count byte on every auto-reload.
// - In capture mode reload-high holds the captured high count byte.
// - Low count byte is low half of 16-bit counter, or own 8-bit timer.
// - High count byte is upper half of 16-bit counter, or own 8-bit timer.
// - High overflow flag sets when high byte wraps; 16-bit wrap in 16-bit mode.
// - High flag requests interrupt when enabled; only software clears it.
// - Low overflow flag sets on low byte wrap in split mode, on 16-bit wrap otherwise; software clears.
// - Low-byte enable plus timer enable make each low overflow request interrupt.
// - With capture enabled, slow oscillator falling edge copies count into reloads.
// - Split bit: 0 one 16-bit timer, 1 two 8-bit auto-reload timers.
// - Run bit enables counting; in split mode it gates only the high byte.
// - External select: 0 system clock over 12, 1 external clock over 8.
// - Per-byte clock selects pick system clock or divided source per byte in split mode; 16-bit mode follows the low select.
// - Reload-low feeds low byte on reload, or holds captured low byte.
// - The pin-capture instance captures on a falling edge of the input pin.
`include "sarct_consts.vh"
`timescale 1ns/100ps
`default_nettype none
module sarct_timer #(
  parameter [7:0] CTRL_ADDR = `SARCT_B_CTRL_ADDR,
  parameter [7:0] RLL_ADDR = `SARCT_B_RLL_ADDR,
  parameter [7:0] RLH_ADDR = `SARCT_B_RLH_ADDR,
  parameter [7:0] CNTL_ADDR = `SARCT_B_CNTL_ADDR,
  parameter [7:0] CNTH_ADDR = `SARCT_B_CNTH_ADDR,
  parameter CAPTURE_FROM_PIN = 0
) (
  input wire clk, // System clock.
  input wire rst, // Synchronous reset, active high.
  input wire [7:0] sfr_addr, // Register address.
  input wire [7:0] sfr_wdata, // Write data.
  input wire sfr_wr, // Write strobe, one cycle.
  input wire timer_irq_enable, // Timer interrupt enable from the interrupt controller.
  input wire high_byte_clock_select, // 1 runs the high byte on the system clock in split mode.
  input wire low_byte_clock_select, // 1 runs the low byte on the system clock.
  input wire ext_clk_in, // External oscillator clock, sampled.
  input wire lfo_in, // Slow oscillator output.
  input wire capture_input_pin, // Timer input pin.
  output reg [7:0] sfr_rdata_r, // Read data for the address of the previous cycle.
  output reg irq_r // Timer interrupt request.
);
  reg [7:0] count_low_byte_r;
  reg [7:0] count_high_byte_r;
  reg [7:0] reload_low_byte_r;
  reg [7:0] reload_high_byte_r;
  reg high_overflow_flag_r;
  reg low_overflow_flag_r;
  reg low_overflow_irq_enable_r;
  reg capture_enable_r;
  reg split_mode_r;
  reg run_control_r;
  reg external_clock_select_r;
  reg [`SARCT_DIV_W-1:0] sys_div_r;
  reg [`SARCT_DIV_W-1:0] ext_div_r;
  reg ext_prev_r;
  reg cap_prev_r;
  reg [7:0] cnt_l_nxt;
  reg [7:0] cnt_h_nxt;
  reg [7:0] rll_nxt;
  reg [7:0] rlh_nxt;
  reg hflag_set;
  reg lflag_set;
  reg [7:0] rdata_nxt;
  wire wr_ctrl;
  wire wr_rll;
  wire wr_rlh;
  wire wr_cntl;
  wire wr_cnth;
  wire ext_rise;
  wire sys_tick;
  wire ext_tick;
  wire base_tick;
  wire low_tick;
  wire high_tick;
  wire cap_src;
  wire cap_event;
  wire [15:0] cnt16;
  wire [15:0] cnt16_inc;

  // Register write decodes, one strobe for each addressed register.
  assign wr_ctrl = sfr_wr && (sfr_addr == CTRL_ADDR);
  assign wr_rll = sfr_wr && (sfr_addr == RLL_ADDR);
  assign wr_rlh = sfr_wr && (sfr_addr == RLH_ADDR);
  assign wr_cntl = sfr_wr && (sfr_addr == CNTL_ADDR);
  assign wr_cnth = sfr_wr && (sfr_addr == CNTH_ADDR);

  // A rising edge of the external clock, seen in the first system clock cycle that it reads high.
  assign ext_rise = ext_clk_in && !ext_prev_r;

  // Base tick is the system clock over 12 or the external clock over 8.
  // The external source must be slow enough for the system clock to see each level.
  assign sys_tick = (sys_div_r == `SARCT_SYS_DIV - 1);
  assign ext_tick = (ext_div_r == `SARCT_EXT_DIV - 1) && ext_rise;
  assign base_tick = external_clock_select_r ? ext_tick : sys_tick;

  // Each byte may instead take the undivided system clock in split mode; 16-bit mode uses the low select only.
  // In split mode the two bytes may therefore run from different sources.
  assign low_tick = low_byte_clock_select ? 1'b1 : base_tick;
  assign high_tick = high_byte_clock_select ? 1'b1 : base_tick;

  // Capture source differs between the two instances.
  // Only a falling edge between two samples counts, so a level held low captures once.
  assign cap_src = (CAPTURE_FROM_PIN != 0) ? capture_input_pin : lfo_in;
  assign cap_event = capture_enable_r && cap_prev_r && !cap_src;

  // The 16-bit view of the count, and its successor.
  assign cnt16 = {count_high_byte_r, count_low_byte_r};
  assign cnt16_inc = cnt16 + 16'h0001;

  // System clock prescaler; it runs free from reset, so the first tick after
  // setting the run bit may come after anything from 1 to 12 cycles.
  always @(posedge clk)
  begin
    if (rst)
    begin
      sys_div_r <= {`SARCT_DIV_W{1'b0}};
    end
    else
    begin
      sys_div_r <= sys_tick ? {`SARCT_DIV_W{1'b0}} : sys_div_r + 4'h1;
    end
  end

  // External clock prescaler; it advances once for each rising edge,
  // and the previous level is kept for the edge detector.
  always @(posedge clk)
  begin
    if (rst)
    begin
      ext_div_r <= {`SARCT_DIV_W{1'b0}};
      ext_prev_r <= 1'b0;
    end
    else
    begin
      ext_prev_r <= ext_clk_in;
      if (ext_rise)
      begin
        ext_div_r <= ext_tick ? {`SARCT_DIV_W{1'b0}} : ext_div_r + 4'h1;
      end
    end
  end

  // Previous level of the capture source, for falling-edge detection;
  // it resets low so that a source already low at reset gives no false edge.
  always @(posedge clk)
  begin
    if (rst)
    begin
      cap_prev_r <= 1'b0;
    end
    else
    begin
      cap_prev_r <= cap_src;
    end
  end

  // Counting, reload, capture and flag events.
  // Every output starts from its held value or from zero, so no path infers a latch.
  always @*
  begin
    cnt_l_nxt = count_low_byte_r;
    cnt_h_nxt = count_high_byte_r;
    rll_nxt = reload_low_byte_r;
    rlh_nxt = reload_high_byte_r;
    hflag_set = 1'b0;
    lflag_set = 1'b0;
    // 16-bit mode steps both bytes together on the low byte's tick.
    if (!split_mode_r)
    begin
      if (run_control_r && low_tick)
      begin
        if (cnt16 == 16'hffff)
        begin
          hflag_set = 1'b1;
          lflag_set = 1'b1;
          // Capture mode runs free; otherwise reload in the flag cycle.
          cnt_l_nxt = capture_enable_r ? 8'h00 : reload_low_byte_r;
          cnt_h_nxt = capture_enable_r ? 8'h00 : reload_high_byte_r;
        end
        else
        begin
          cnt_l_nxt = cnt16_inc[7:0];
          cnt_h_nxt = cnt16_inc[15:8];
        end
      end
    end
    else
    begin
      // Split mode: the low byte ignores the run bit.
      if (low_tick)
      begin
        if (count_low_byte_r == 8'hff)
        begin
          lflag_set = 1'b1;
          cnt_l_nxt = capture_enable_r ? 8'h00 : reload_low_byte_r;
        end
        else
        begin
          cnt_l_nxt = count_low_byte_r + 8'h01;
        end
      end
      if (run_control_r && high_tick)
      begin
        if (count_high_byte_r == 8'hff)
        begin
          hflag_set = 1'b1;
          cnt_h_nxt = capture_enable_r ? 8'h00 : reload_high_byte_r;
        end
        else
        begin
          cnt_h_nxt = count_high_byte_r + 8'h01;
        end
      end
    end
    // Software writes to the count bytes take precedence over counting.
    if (wr_cntl)
    begin
      cnt_l_nxt = sfr_wdata;
    end
    if (wr_cnth)
    begin
      cnt_h_nxt = sfr_wdata;
    end
    // Reload writes, then capture, which wins over a same-cycle write.
    if (wr_rll)
    begin
      rll_nxt = sfr_wdata;
    end
    if (wr_rlh)
    begin
      rlh_nxt = sfr_wdata;
    end
    if (cap_event)
    begin
      rll_nxt = count_low_byte_r;
      rlh_nxt = count_high_byte_r;
      hflag_set = 1'b1;
    end
  end

  // Read data mux; the reserved bit reads zero.
  // Reads are registered, so data appears one cycle after its address.
  always @*
  begin
    rdata_nxt = 8'h00;
    case (sfr_addr)
      CTRL_ADDR: rdata_nxt = {high_overflow_flag_r, low_overflow_flag_r,
        low_overflow_irq_enable_r, capture_enable_r, split_mode_r, run_control_r,
        1'b0, external_clock_select_r};
      RLL_ADDR: rdata_nxt = reload_low_byte_r;
      RLH_ADDR: rdata_nxt = reload_high_byte_r;
      CNTL_ADDR: rdata_nxt = count_low_byte_r;
      CNTH_ADDR: rdata_nxt = count_high_byte_r;
      default: rdata_nxt = 8'h00;
    endcase
  end

  // Register state; a hardware flag set wins over a same-cycle software clear.
  // Clearing a flag needs a write of zero; writing one sets it by software.
  always @(posedge clk)
  begin
    if (rst)
    begin
      count_low_byte_r <= `SARCT_REG_RESET;
      count_high_byte_r <= `SARCT_REG_RESET;
      reload_low_byte_r <= `SARCT_REG_RESET;
      reload_high_byte_r <= `SARCT_REG_RESET;
      high_overflow_flag_r <= 1'b0;
      low_overflow_flag_r <= 1'b0;
      low_overflow_irq_enable_r <= 1'b0;
      capture_enable_r <= 1'b0;
      split_mode_r <= 1'b0;
      run_control_r <= 1'b0;
      external_clock_select_r <= 1'b0;
      sfr_rdata_r <= 8'h00;
      irq_r <= 1'b0;
    end
    else
    begin
      count_low_byte_r <= cnt_l_nxt;
      count_high_byte_r <= cnt_h_nxt;
      reload_low_byte_r <= rll_nxt;
      reload_high_byte_r <= rlh_nxt;
      high_overflow_flag_r <= hflag_set |
        (wr_ctrl ? sfr_wdata[`SARCT_HFLAG_BIT] : high_overflow_flag_r);
      low_overflow_flag_r <= lflag_set |
        (wr_ctrl ? sfr_wdata[`SARCT_LFLAG_BIT] : low_overflow_flag_r);
      // Software-owned control bits; bit 1 has no storage and reads zero.
      if (wr_ctrl)
      begin
        low_overflow_irq_enable_r <= sfr_wdata[`SARCT_LIEN_BIT];
        capture_enable_r <= sfr_wdata[`SARCT_CAPEN_BIT];
        split_mode_r <= sfr_wdata[`SARCT_SPLIT_BIT];
        run_control_r <= sfr_wdata[`SARCT_RUN_BIT];
        external_clock_select_r <= sfr_wdata[`SARCT_XCLK_BIT];
      end
      sfr_rdata_r <= rdata_nxt;
      // The request follows the flags one cycle later and drops when they clear.
      irq_r <= timer_irq_enable && (high_overflow_flag_r ||
        (low_overflow_flag_r && low_overflow_irq_enable_r));
    end
  end
endmodule
`default_nettype wire

// ### test/sarct_monitor.sv
// Port checker for the split timer, bound to its top module.
`timescale 1ns/100ps
`default_nettype none
module sarct_monitor (
  input wire clk, rst, sfr_wr, timer_irq_enable, // Clock, reset, strobe, enable.
  input wire high_byte_clock_select, low_byte_clock_select, // Per-byte clock selects.
  input wire ext_clk_in, lfo_in, capture_input_pin, // Count and capture sources.
  input wire [7:0] sfr_addr, sfr_wdata, sfr_rdata_r, // Register access.
  input wire irq_r // Interrupt request.
);
  reg [7:0] ctl_r;
  reg [7:0] rll_r;
  wire lo_rd = sfr_addr == 8'h94 && !sfr_wr;
  wire lo_run = low_byte_clock_select && (ctl_r[2] || ctl_r[3]);
  wire hi_off = ctl_r[3] && !ctl_r[2];
  wire lo_ar = low_byte_clock_select && ctl_r[3] && !ctl_r[4];
  // Shadows of the software-owned control bits and the low reload byte.
  always @(posedge clk)
  begin
    ctl_r <= rst ? 8'h00 : (sfr_wr && sfr_addr == 8'h91) ? sfr_wdata : ctl_r;
    rll_r <= rst ? 8'h00 : (sfr_wr && sfr_addr == 8'h92) ? sfr_wdata : rll_r;
  end
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);
  // Read data is registered, so each check looks one cycle after its address.
  reset_clear_a: assert property ($fell(rst) |-> sfr_rdata_r == 8'h00 && !irq_r)
    else $error("not cleared by reset");
  irq_gate_a: assert property (!timer_irq_enable |=> !irq_r)
    else $error("request while disabled");
  irq_hold_a: assert property (irq_r && timer_irq_enable && !$past(sfr_wr) |=> irq_r)
    else $error("request dropped");
  rsvd_zero_a: assert property (sfr_addr == 8'h91 |=> !sfr_rdata_r[1])
    else $error("reserved bit set");
  unmapped_a: assert property (sfr_addr < 8'h91 || sfr_addr > 8'h95 |=> sfr_rdata_r == 8'h00)
    else $error("unmapped read not zero");
  cnt_step_a: assert property (lo_rd && $past(lo_rd) && $past(lo_run)
    && sfr_rdata_r != 8'hff |=> sfr_rdata_r == $past(sfr_rdata_r) + 8'h01)
    else $error("low byte did not step");
  hi_hold_a: assert property (sfr_addr == 8'h95 && $past(sfr_addr) == 8'h95
    && !$past(sfr_wr) && $past(hi_off) |=> $stable(sfr_rdata_r))
    else $error("stopped high byte moved");
  lo_reload_a: assert property (lo_rd && $past(lo_rd) && $past(lo_ar)
    && sfr_rdata_r == 8'hff |=> sfr_rdata_r == rll_r) else $error("low byte not reloaded");
  cover property (irq_r && ctl_r[3]);
  cover property (lo_rd && sfr_rdata_r == 8'hff);
  cover property ($fell(lfo_in) && ctl_r[4]);
endmodule
bind sarct_timer sarct_monitor sarct_monitor_inst (.clk, .rst, .sfr_addr, .sfr_wdata, .sfr_wr,
  .timer_irq_enable, .high_byte_clock_select, .low_byte_clock_select, .ext_clk_in, .lfo_in,
  .capture_input_pin, .sfr_rdata_r, .irq_r);
`default_nettype wire

// ### test/split_autoreload_capture_timer_test.sv
// Self-checking register-level bench for the split timer.
`timescale 1ns/100ps
`default_nettype none
module split_autoreload_capture_timer_test;
  logic clk = 0, rst = 1, wr = 0, ien = 0, lsel = 0, xck = 0, lfo = 1, hsel = 0, pin = 1;
  logic [7:0] addr = 8'h00, wd = 8'h00, v, w;
  logic [7:0] regs [7] = '{8'h91, 8'h92, 8'h93, 8'h94, 8'h95, 8'h96, 8'hcb};
  wire [7:0] rdat;
  wire irq;
  int err_count = 0, n_compared = 0;
  sarct_timer sarct_timer_inst (.clk(clk), .rst(rst), .sfr_addr(addr), .sfr_wdata(wd),
    .sfr_wr(wr), .timer_irq_enable(ien), .high_byte_clock_select(hsel),
    .low_byte_clock_select(lsel), .ext_clk_in(xck), .lfo_in(lfo), .capture_input_pin(pin),
    .sfr_rdata_r(rdat), .irq_r(irq));
  always #12.5 clk = ~clk;
  // Cycle ceiling that cuts a hang short.
  initial
  begin
    repeat (2000) @(posedge clk);
    err_count++;
    close_out;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // A write holds its strobe for one edge, then lets an idle edge pass.
  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wd = d;
    wr = 1;
    step(1);
    wr = 0;
    step(1);
  endtask
  task automatic wrs(input logic [15:0] q[$]);
    foreach (q[i])
      wrr(q[i][15:8], q[i][7:0]);
  endtask
  task automatic rdv(input logic [7:0] a, output logic [7:0] q);
    addr = a;
    step(1);
    q = rdat;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    rdv(a, v);
    chk($sformatf("reg %h", a), e, v);
  endtask
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    step(4);
    rst = 0;
    step(1);
    foreach (regs[i])
      rdc(regs[i], 8'h00);
    wrr(8'h93, 8'h5a);
    rdc(8'h93, 8'h5a);
    wrr(8'h91, 8'h09);
    rdc(8'h91, 8'h09);
    $display("test registers done");
    wrs('{16'h9105, 16'h9400});
    repeat (16)
    begin
      xck = 1;
      step(2);
      xck = 0;
      step(2);
    end
    step(4);
    rdc(8'h94, 8'h02);
    wrr(8'h91, 8'h04);
    rdv(8'h94, v);
    step(23);
    rdv(8'h94, w);
    chk("divide by twelve", v + 8'h02, w);
    $display("test clocks done");
    wrs('{16'h9100, 16'h9234, 16'h9312, 16'h94fe, 16'h95ff});
    lsel = 1;
    ien = 1;
    wrr(8'h91, 8'h04);
    rdv(8'h94, v);
    step(6);
    rdc(8'h91, 8'hc4);
    rdc(8'h95, 8'h12);
    chk("irq", 8'h01, {7'h00, irq});
    wrr(8'h91, 8'h04);
    step(2);
    chk("irq", 8'h00, {7'h00, irq});
    $display("test overflow done");
    wrs('{16'h9100, 16'h92f0, 16'h9577, 16'h94fd, 16'h9128});
    rdv(8'h94, v);
    step(8);
    rdc(8'h91, 8'h68);
    chk("irq", 8'h01, {7'h00, irq});
    rdc(8'h95, 8'h77);
    step(2);
    wrr(8'h91, 8'h08);
    step(20);
    chk("irq", 8'h00, {7'h00, irq});
    rdc(8'h91, 8'h48);
    $display("test split done");
    wrs('{16'h9100, 16'h9410, 16'h95ab, 16'h9110});
    lfo = 0;
    step(4);
    rdc(8'h92, 8'h10);
    rdc(8'h93, 8'hab);
    rdc(8'h91, 8'h90);
    chk("irq", 8'h01, {7'h00, irq});
    $display("test capture done");
    // This instance captures on the slow oscillator, so the pin is ignored.
    wrs('{16'h9110, 16'h9455});
    pin = 0;
    step(4);
    rdc(8'h92, 8'h10);
    rdc(8'h91, 8'h10);
    chk("irq", 8'h00, {7'h00, irq});
    // High byte on the undivided system clock in split mode with run set.
    wrs('{16'h9100, 16'h9500, 16'h910c});
    lsel = 0;
    hsel = 1;
    rdv(8'h95, v);
    step(9);
    rdv(8'h95, w);
    chk("high byte clock", v + 8'h0a, w);
    $display("test select done");
    close_out;
  end
endmodule
`default_nettype wire
